// File: bench/coder_model.sv
/* Coder model: takes offered bytes, finishes the end of frame.
   Assumes the link block clock and reset. */
`timescale 1ns/1ps
module coder_model (
    input wire logic clk, rst_n, stall, coderValid, coderEndFrame,
    output logic coderReady = 1'b0, coderEndDone = 1'b0, coderTxBit = 1'b1
);
    logic [1:0] endCnt_r = 2'h0; // cycles left of the end gap
    // random accept gives prompt and slow answers; stall holds it off
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coderReady <= 1'b0;
            endCnt_r <= 2'h0;
        end else begin
            coderReady <= !stall && 1'($urandom);
            coderTxBit <= coderTxBit ^ (coderValid && coderReady); // line bit moves per byte
            coderEndDone <= endCnt_r == 2'h1;
            endCnt_r <= coderEndFrame ? 2'h3 : endCnt_r - 2'(endCnt_r != 2'h0);
        end
    end
endmodule

// File: bench/netlink_frame_props.sv
/* Checker on the ports of the link frame block.
   Assumes a bind from the bench top, one clock domain. */
`timescale 1ns/1ps
module netlink_frame_props (
    input wire logic clk, rst_n, collisionDetected, transmitterEnabled, collision_flag,
    input wire logic coderEndDone, frame_tx_done, decoderValid, receiverEnabled, rx_holding_ready,
    input wire logic early_termination_flag, tx_holding_ready, status_clear_cmd, txdPin, rxdPin,
    input wire logic [7:0] rxByte, decoderByte,
    input wire netlink_pkg::chan_mode_type channelMode
);
    import netlink_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    coll_set_a: assert property (collisionDetected && transmitterEnabled |=> collision_flag) else $error("no flag");
    tx_done_a: assert property (coderEndDone |=> frame_tx_done) else $error("no frame done");
    rx_take_a: assert property (decoderValid && receiverEnabled |=> rx_holding_ready && rxByte == $past(decoderByte))
        else $error("byte lost");
    hold_low_a: assert property (early_termination_flag |-> !tx_holding_ready) else $error("ready free");
    flag_clear_a: assert property (status_clear_cmd && !collisionDetected |=> !collision_flag && !early_termination_flag)
        else $error("flags stay");
    echo_pin_a: assert property (channelMode == CH_ECHO |=> txdPin == $past(rxdPin)) else $error("no echo");
    local_pin_a: assert property (channelMode == CH_LOCAL |=> txdPin) else $error("pin not idle");
    remote_off_a: assert property (channelMode == CH_REMOTE |-> !transmitterEnabled && !receiverEnabled)
        else $error("engines on");
    // main scenarios
    cover property ($rose(early_termination_flag));
    cover property (frame_tx_done && !early_termination_flag);
    cover property (channelMode == CH_REMOTE);
endmodule

// File: bench/netlink_frame_tb.sv
/* Bench of the link frame block.
   Assumes the coder model and the bound checker. */
`timescale 1ns/1ps
`include "netlink_cfg.svh"
module netlink_frame_tb;
    import netlink_pkg::*;
    logic clk = 0, rst_n = 0, stall = 0, rxdPin = 1, txHoldingWrite = 0, linkHeaderWrite = 0;
    logic rxHoldingRead = 0, cfgWrite = 0, cfgRead = 0, status_clear_cmd = 0, collisionDetected = 0;
    logic decoderValid = 0, decoderEndFrame = 0, tx_holding_ready, rx_holding_ready, frame_tx_done;
    logic frame_rx_done, collision_flag, early_termination_flag, write_violation_flag, coderValid;
    logic coderReady, coderEndFrame, coderEndDone, coderTxBit, receiverBit, transmitterEnabled;
    logic receiverEnabled, txdPin;
    logic [7:0] txByte = 0, decoderByte = 0, rxByte, coderByte;
    logic [4:0] cfgIndex = 0, violation_source;
    logic [31:0] cfgWriteData = 0, cfgReadData, manchester_config;
    chan_mode_type channelMode;
    int mismatches = 0, num_checks = 0, cyc = 0;
    logic [7:0] q[$]; // bytes the coder should see
    netlink_frame uut (.*, .linkModeConfig());
    coder_model partner (.*);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cfgw(input logic [4:0] i, input logic [31:0] d);
        @(posedge clk) begin cfgWrite <= 1; cfgIndex <= i; cfgWriteData <= d; end
        @(posedge clk) cfgWrite <= 0;
    endtask
    task automatic cfgr(input logic [4:0] i, input logic [31:0] e);
        @(posedge clk) begin cfgRead <= 1; cfgIndex <= i; end
        @(posedge clk) cfgRead <= 0;
        @(posedge clk) chk(cfgReadData, e);
    endtask
    // one byte once ready; its note goes in with it unless h[1] is set
    task automatic sendb(input logic [7:0] b, input logic [1:0] h);
        @(posedge clk);
        for (int k = 0; k < 300 && !tx_holding_ready; k++) @(posedge clk);
        txHoldingWrite <= !h[0]; linkHeaderWrite <= h[0]; txByte <= b;
        if (!h[1]) q.push_back(b);
        @(posedge clk) begin txHoldingWrite <= 0; linkHeaderWrite <= 0; end
    endtask
    task automatic pulseClear;
        @(posedge clk) status_clear_cmd <= 1;
        @(posedge clk) status_clear_cmd <= 0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial forever #5 clk = ~clk;
    // oldest note against each byte the coder takes
    always @(posedge clk) if (coderValid && coderReady) chk(coderByte, q.size() ? q.pop_front() : 9'h1FF);
    always @(posedge clk) if (++cyc == 20000) begin mismatches++; end_sim; end
    initial begin
        void'($urandom(13495));
        repeat (20) @(posedge clk);
        rst_n <= 1;
        chk(manchester_config, `RST_MANCHESTER);
        cfgr(`IDX_BIT_RATIO, `RST_BIT_RATIO);
        // length from register, then from stream
        for (int n = 0; n < 2; n++) begin
            cfgw(n ? `IDX_LINK_MODE : `IDX_DATA_LENGTH, n ? 32'h100 : 32'h3);
            sendb(8'($urandom), 1);
            if (n) sendb(8'h2, 2);
            repeat (3 - n) sendb(8'($urandom), 0);
            for (int k = 0; k < 500 && !frame_tx_done; k++) @(posedge clk);
            chk(frame_tx_done, 1);
            chk(q.size(), 0);
            pulseClear();
            @(posedge clk) chk(frame_tx_done, 0);
        end
        // one received byte, then end of frame
        @(posedge clk) begin decoderValid <= 1; decoderByte <= 8'($urandom); end
        @(posedge clk) begin decoderValid <= 0; decoderEndFrame <= 1; end
        @(posedge clk) decoderEndFrame <= 0;
        chk(rxByte, decoderByte);
        chk(rx_holding_ready, 1);
        rxHoldingRead <= 1;
        @(posedge clk) rxHoldingRead <= 0;
        chk(frame_rx_done, 1);
        @(posedge clk) chk(rx_holding_ready, 0);
        // coder stalled: fill, then a collision cuts the frame
        stall <= 1;
        cfgw(`IDX_LINK_MODE, 32'h20);
        cfgw(`IDX_DATA_LENGTH, 32'hFF);
        sendb(8'($urandom), 1);
        repeat (20) if (tx_holding_ready) sendb(8'($urandom), 0);
        chk(tx_holding_ready, 0);
        @(posedge clk) collisionDetected <= 1;
        @(posedge clk) collisionDetected <= 0;
        repeat (5) @(posedge clk);
        chk({collision_flag, early_termination_flag, frame_tx_done}, 3'h7);
        chk({tx_holding_ready, coderValid}, 2'h0);
        q.delete();
        stall <= 0;
        pulseClear();
        repeat (3) @(posedge clk);
        chk({tx_holding_ready, early_termination_flag}, 2'h2);
        // every channel mode, random line level
        for (int m = 0; m < 4; m++) begin
            cfgw(`IDX_MODE, 32'(m) << 14);
            rxdPin <= 1'($urandom);
            repeat (3) @(posedge clk);
            chk(txdPin, m == 0 ? coderTxBit : m == 2 ? 1'b1 : rxdPin);
            chk(receiverBit, m == 2 ? coderTxBit : m == 3 ? 1'b1 : rxdPin);
        end
        // locked: every protected index refused and reported
        cfgw(`IDX_MODE, 32'h0);
        cfgw(`IDX_PROT_MODE, 32'h1);
        for (int i = 0; i < `NUM_PROTECTED; i++) begin
            cfgw(i[4:0], $urandom);
            @(posedge clk) chk({write_violation_flag, violation_source}, {1'b1, i[4:0]});
        end
        chk(channelMode, CH_NORMAL);
        cfgr(`IDX_PROT_STATUS, 32'h0000_0D01);
        chk(write_violation_flag, 0);
        cfgw(`IDX_PROT_MODE, 32'h0);
        cfgw(`IDX_MODE, 32'h0000_8000);
        @(posedge clk) chk(channelMode, CH_LOCAL);
        end_sim;
    end
endmodule
bind netlink_frame netlink_frame_props props (.*);

// File: design/byte_fifo.sv
/*
 * Transmit byte buffer: flip-flop storage addressed by read and write indices.
 * Assumes a single clock; full and empty are exact, no word is lost or duplicated.
 */
`timescale 1ns/1ps
`include "netlink_cfg.svh"
module byte_fifo #(
    parameter int WIDTH = `TXBUF_WIDTH,
    parameter int DEPTH = `TXBUF_DEPTH
) (
    input  wire logic clk,
    input  wire logic rst_n,
    byte_fifo_if.buffer port
);
    import netlink_pkg::*;
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage
        logic [AW-1:0]               rdIdx; // oldest word
        logic [AW-1:0]               wrIdx; // next free slot
        logic [AW:0]                 count; // words held
    } fifo_state_type;

    fifo_state_type s_r;   // registered state
    fifo_state_type s_nxt; // next state

    logic doPush; // word accepted this cycle
    logic doPop;  // word removed this cycle

    // index advance with wrap, shared by both pointers
    function automatic logic [AW-1:0] advance(input logic [AW-1:0] idx);
        if (idx == AW'(DEPTH - 1)) begin
            return '0;
        end
        return idx + AW'(1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // handshake outputs straight from the count
    assign port.pushReady = (s_r.count != (AW + 1)'(DEPTH));
    assign port.popValid  = (s_r.count != '0);
    assign port.popData   = s_r.mem[s_r.rdIdx];
    assign doPush = port.pushValid && port.pushReady && !port.flush;
    assign doPop  = port.popValid && port.popReady;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt = s_r;
        if (port.flush) begin
            // flush only drops what is held; a push in the same cycle is refused
            s_nxt.rdIdx = '0;
            s_nxt.wrIdx = '0;
            s_nxt.count = '0;
        end else begin
            if (doPush) begin
                s_nxt.mem[s_r.wrIdx] = port.pushData;
                s_nxt.wrIdx = advance(s_r.wrIdx);
            end
            if (doPop) begin
                s_nxt.rdIdx = advance(s_r.rdIdx);
            end
            if (doPush && !doPop) begin
                s_nxt.count = s_r.count + (AW + 1)'(1);
            end else if (doPop && !doPush) begin
                s_nxt.count = s_r.count - (AW + 1)'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// File: design/byte_fifo_if.sv
/*
 * Carrier between the link block and its transmit buffer: a push side and a
 * pop side, each with valid and ready.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface byte_fifo_if #(parameter int WIDTH = 8);
    logic             pushValid;  // writer offers a word
    logic             pushReady;  // buffer has room
    logic [WIDTH-1:0] pushData;   // word offered
    logic             popValid;   // buffer holds a word
    logic             popReady;   // reader takes the word
    logic [WIDTH-1:0] popData;    // oldest word
    logic             flush;      // drop everything held

    modport buffer (input pushValid, pushData, popReady, flush, output pushReady, popValid, popData);
    modport user   (output pushValid, pushData, popReady, flush, input pushReady, popValid, popData);
endinterface

// File: design/netlink_cfg.svh
/*
 * Constants of the control-network link block: register indices, field positions,
 * reset values and buffer sizes.
 * Assumes it is included by its bare name from every file that needs a constant.
 */
`ifndef NETLINK_CFG_SVH
`define NETLINK_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// configuration register indices on the cfgIndex port
`define IDX_MODE          5'h00
`define IDX_BAUD          5'h01
`define IDX_RX_TIMEOUT    5'h02
`define IDX_TIMEGUARD     5'h03
`define IDX_BIT_RATIO     5'h04
`define IDX_IR_FILTER     5'h05
`define IDX_MANCHESTER    5'h06
`define IDX_LINK_MODE     5'h07
`define IDX_BETA1_TX      5'h08
`define IDX_BETA1_RX      5'h09
`define IDX_PRIORITY      5'h0A
`define IDX_IDT_TX        5'h0B
`define IDX_IDT_RX        5'h0C
`define IDX_CHIP_DIFF     5'h0D
`define IDX_DATA_LENGTH   5'h0E
`define IDX_PROT_MODE     5'h0F
`define IDX_PROT_STATUS   5'h10
`define NUM_PROTECTED     14
`define NUM_CFG           15

////////////////////////////////////////////////////////////////////////////////
// field positions
`define MODE_CHMODE_LSB   14
`define LMODE_TERM_BIT    5
`define LMODE_LENBUF_BIT  8
`define PMODE_LOCK_BIT    0
`define PSTAT_SRC_LSB     8

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_BIT_RATIO     32'h0000_0174
`define RST_MANCHESTER    32'hB001_1004
`define RST_ZERO          32'h0000_0000

////////////////////////////////////////////////////////////////////////////////
// transmit buffer
`define TXBUF_WIDTH       8
`define TXBUF_DEPTH       16

`endif

// File: design/netlink_frame.sv
/*
 * Control-network link frame block: transmit sequencing from a byte buffer,
 * receive holding, early termination on collision, channel test modes and
 * write protection of the configuration registers.
 * Assumes an outside Manchester coder/decoder, collision detector and a
 * software or DMA writer on the plain register ports; all inputs synchronous to clk.
 */
//
// Overview of operation
// - frame-sent flag rises after whole frame
// - frame-received flag rises at frame end
// - ready flags serve as DMA request triggers
// - length-in-buffer mode takes length from stream
// - link header is first byte of stream
// - transmission may stop before DMA end
// - early stop: end frame, hold ready, flags
// - ready held until collision flags cleared
// - normal mode: pins to receiver and transmitter
// - echo mode: receive pin copied to transmit
// - local loopback: transmitter feeds receiver, pin high
// - remote loopback: pins joined, engines disabled
// - write-lock bit protects configuration registers
// - blocked write sets flag and records source
// - reading protection status clears violation flag
// - fourteen configuration registers are protected
// - early-termination flag set on collision cut
// - status-clear command clears link error flags
//
`timescale 1ns/1ps
`include "netlink_cfg.svh"
module netlink_frame (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // holding-register writes and reads
    input  wire logic                    txHoldingWrite,
    input  wire logic                    linkHeaderWrite,
    input  wire logic [7:0]              txByte,
    output logic                         tx_holding_ready,
    input  wire logic                    rxHoldingRead,
    output logic [7:0]                   rxByte,
    output logic                         rx_holding_ready,
    // configuration access
    input  wire logic                    cfgWrite,
    input  wire logic                    cfgRead,
    input  wire logic [4:0]              cfgIndex,
    input  wire logic [31:0]             cfgWriteData,
    output logic [31:0]                  cfgReadData,
    input  wire logic                    status_clear_cmd,
    // status
    output logic                         frame_tx_done,
    output logic                         frame_rx_done,
    output logic                         collision_flag,
    output logic                         early_termination_flag,
    output logic                         write_violation_flag,
    output logic [4:0]                   violation_source,
    output netlink_pkg::chan_mode_type   channelMode,
    output logic [31:0]                  manchester_config,
    output logic [31:0]                  linkModeConfig,
    // outside coder, decoder and collision detector
    output logic [7:0]                   coderByte,
    output logic                         coderValid,
    input  wire logic                    coderReady,
    output logic                         coderEndFrame,
    input  wire logic                    coderEndDone,
    input  wire logic                    coderTxBit,
    input  wire logic                    collisionDetected,
    input  wire logic [7:0]              decoderByte,
    input  wire logic                    decoderValid,
    input  wire logic                    decoderEndFrame,
    output logic                         receiverBit,
    output logic                         transmitterEnabled,
    output logic                         receiverEnabled,
    // serial line
    input  wire logic                    rxdPin,
    output logic                         txdPin
);
    import netlink_pkg::*;

    typedef struct packed {
        tx_state_type                      txState;   // frame sequencer
        logic [7:0]                        txCount;   // payload bytes still to send
        logic [7:0]                        outByte;   // byte offered to the coder
        logic                              outValid;  // offer pending
        logic                              endPulse;  // end-of-frame request
        logic                              txDone;    // frame sent
        logic                              rxDone;    // frame received
        logic                              collision; // collision seen
        logic                              earlyTerm; // frame cut short
        logic [7:0]                        rxHold;    // received byte
        logic                              rxReady;   // received byte waiting
        logic                              violation; // blocked write seen
        logic [4:0]                        violSrc;   // register of blocked write
        logic                              lockOn;    // write lock enabled
        logic [`NUM_CFG-1:0][31:0]         cfg;       // configuration registers
        logic [31:0]                       readData;  // configuration read answer
        logic                              txdOut;    // line output
        logic                              recvOut;   // receiver input
    } state_type;

    state_type s_r;   // registered state
    state_type s_nxt; // next state

    byte_fifo_if #(.WIDTH(`TXBUF_WIDTH)) txBuf ();

    chan_mode_type modeSel;  // decoded channel mode
    logic          lenInBuf; // length travels in the byte stream
    logic          termOn;   // collision ends the frame
    logic          txOn;     // transmitter has effect
    logic          rxOn;     // receiver has effect
    logic          coderFree; // coder can take a new byte

    // registers covered by the write lock
    function automatic logic isProtected(input logic [4:0] idx);
        return idx < 5'(`NUM_PROTECTED);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // transmit buffer
    byte_fifo #(
        .WIDTH (`TXBUF_WIDTH),
        .DEPTH (`TXBUF_DEPTH)
    ) txFifo (
        .clk   (clk),
        .rst_n (rst_n),
        .port  (txBuf.buffer)
    );

    ////////////////////////////////////////////////////////////////////////////
    // configuration decode
    assign modeSel   = chan_mode_type'(s_r.cfg[`IDX_MODE][`MODE_CHMODE_LSB +: 2]);
    assign lenInBuf  = s_r.cfg[`IDX_LINK_MODE][`LMODE_LENBUF_BIT];
    assign termOn    = s_r.cfg[`IDX_LINK_MODE][`LMODE_TERM_BIT];
    assign txOn      = (modeSel != CH_REMOTE);
    assign rxOn      = (modeSel != CH_REMOTE);
    assign coderFree = !s_r.outValid || coderReady;

    // header and payload share one stream, header first
    assign txBuf.pushValid = (txHoldingWrite || linkHeaderWrite) && (s_r.txState != TX_HOLD);
    assign txBuf.pushData  = txByte;
    // held buffer is drained so stale DMA bytes never reach a later frame
    assign txBuf.flush     = (s_r.txState == TX_HOLD);
    assign txBuf.popReady  = txOn && coderFree && !collisionDetected &&
                             ((s_r.txState == TX_IDLE) || (s_r.txState == TX_LEN) ||
                              (s_r.txState == TX_DATA));

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign tx_holding_ready       = txBuf.pushReady && (s_r.txState != TX_HOLD);
    assign rx_holding_ready       = s_r.rxReady;
    assign rxByte                 = s_r.rxHold;
    assign cfgReadData            = s_r.readData;
    assign frame_tx_done          = s_r.txDone;
    assign frame_rx_done          = s_r.rxDone;
    assign collision_flag         = s_r.collision;
    assign early_termination_flag = s_r.earlyTerm;
    assign write_violation_flag   = s_r.violation;
    assign violation_source       = s_r.violSrc;
    assign channelMode            = modeSel;
    assign manchester_config      = s_r.cfg[`IDX_MANCHESTER];
    assign linkModeConfig         = s_r.cfg[`IDX_LINK_MODE];
    assign coderByte              = s_r.outByte;
    assign coderValid             = s_r.outValid;
    assign coderEndFrame          = s_r.endPulse;
    assign receiverBit            = s_r.recvOut;
    assign txdPin                 = s_r.txdOut;
    assign transmitterEnabled     = txOn;
    assign receiverEnabled        = rxOn;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.endPulse = 1'b0;
        if (s_r.outValid && coderReady) begin
            s_nxt.outValid = 1'b0;
        end

        // status clear first so that any event below wins
        if (status_clear_cmd) begin
            s_nxt.txDone    = 1'b0;
            s_nxt.rxDone    = 1'b0;
            s_nxt.collision = 1'b0;
            s_nxt.earlyTerm = 1'b0;
        end

        // transmit frame sequencer
        unique case (s_r.txState)
            TX_IDLE: begin
                if (txBuf.popValid && txBuf.popReady) begin
                    // first stream byte is the link header
                    s_nxt.outByte  = txBuf.popData;
                    s_nxt.outValid = 1'b1;
                    s_nxt.txCount  = s_r.cfg[`IDX_DATA_LENGTH][7:0];
                    if (lenInBuf) begin
                        s_nxt.txState = TX_LEN;
                    end else if (s_r.cfg[`IDX_DATA_LENGTH][7:0] == 8'h00) begin
                        s_nxt.txState = TX_EOF;
                    end else begin
                        s_nxt.txState = TX_DATA;
                    end
                end
            end
            TX_LEN: begin
                // length byte steers the count and is not sent on the line
                if (txBuf.popValid && txBuf.popReady) begin
                    s_nxt.txCount = txBuf.popData;
                    s_nxt.txState = (txBuf.popData == 8'h00) ? TX_EOF : TX_DATA;
                end
            end
            TX_DATA: begin
                if (txBuf.popValid && txBuf.popReady) begin
                    s_nxt.outByte  = txBuf.popData;
                    s_nxt.outValid = 1'b1;
                    s_nxt.txCount  = s_r.txCount - 8'h01;
                    if (s_r.txCount == 8'h01) begin
                        s_nxt.txState = TX_EOF;
                    end
                end
            end
            TX_EOF: begin
                // end condition only once the last byte left for the coder
                if (coderFree) begin
                    s_nxt.endPulse = 1'b1;
                    s_nxt.txState  = TX_WAIT;
                end
            end
            TX_WAIT: begin
                if (coderEndDone) begin
                    s_nxt.txDone  = 1'b1;
                    s_nxt.txState = TX_IDLE;
                end
            end
            TX_HOLD: begin
                // ready stays low until both flags are gone
                if (!s_r.collision && !s_r.earlyTerm) begin
                    s_nxt.txState = TX_IDLE;
                end
            end
            default: begin
                s_nxt.txState = TX_IDLE;
            end
        endcase

        // collision reporting and early termination
        if (collisionDetected && txOn) begin
            s_nxt.collision = 1'b1;
            if (termOn && (s_r.txState != TX_IDLE) && (s_r.txState != TX_HOLD)) begin
                // cut the frame; DMA transfer ends short of its count
                s_nxt.outValid  = 1'b0;
                s_nxt.endPulse  = 1'b1;
                s_nxt.txDone    = 1'b1;
                s_nxt.earlyTerm = 1'b1;
                s_nxt.txState   = TX_HOLD;
            end
        end

        // receive holding register; a new byte wins over a read
        if (rxHoldingRead) begin
            s_nxt.rxReady = 1'b0;
        end
        if (decoderValid && rxOn) begin
            s_nxt.rxHold  = decoderByte;
            s_nxt.rxReady = 1'b1;
        end
        if (decoderEndFrame && rxOn) begin
            s_nxt.rxDone = 1'b1;
        end

        // configuration reads; status read clears the violation
        if (cfgRead) begin
            if (cfgIndex == `IDX_PROT_STATUS) begin
                s_nxt.readData = {16'h0000, 3'b000, s_r.violSrc, 7'b0000000, s_r.violation};
                s_nxt.violation = 1'b0;
            end else if (cfgIndex == `IDX_PROT_MODE) begin
                s_nxt.readData = {31'h0000_0000, s_r.lockOn};
            end else if (cfgIndex < 5'(`NUM_CFG)) begin
                s_nxt.readData = s_r.cfg[cfgIndex];
            end else begin
                s_nxt.readData = `RST_ZERO;
            end
        end

        // configuration writes under the lock
        if (cfgWrite) begin
            if (cfgIndex == `IDX_PROT_MODE) begin
                s_nxt.lockOn = cfgWriteData[`PMODE_LOCK_BIT];
            end else if (s_r.lockOn && isProtected(cfgIndex)) begin
                // write dropped, old contents kept
                s_nxt.violation = 1'b1;
                s_nxt.violSrc   = cfgIndex;
            end else if (cfgIndex < 5'(`NUM_CFG)) begin
                s_nxt.cfg[cfgIndex] = cfgWriteData;
            end
        end

        // channel test modes
        unique case (modeSel)
            CH_NORMAL: begin
                s_nxt.recvOut = rxdPin;
                s_nxt.txdOut  = coderTxBit;
            end
            CH_ECHO: begin
                s_nxt.recvOut = rxdPin;
                s_nxt.txdOut  = rxdPin;
            end
            CH_LOCAL: begin
                s_nxt.recvOut = coderTxBit;
                s_nxt.txdOut  = 1'b1;
            end
            CH_REMOTE: begin
                s_nxt.recvOut = 1'b1;
                s_nxt.txdOut  = rxdPin;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; line idles high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r                           <= '0;
            s_r.txState                   <= TX_IDLE;
            s_r.cfg[`IDX_BIT_RATIO]       <= `RST_BIT_RATIO;
            s_r.cfg[`IDX_MANCHESTER]      <= `RST_MANCHESTER;
            s_r.txdOut                    <= 1'b1;
            s_r.recvOut                   <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// File: design/netlink_pkg.sv
/*
 * Types shared by the link block and its transmit buffer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package netlink_pkg;
    // channel test modes, in mode-register encoding order
    typedef enum logic [1:0] {CH_NORMAL, CH_ECHO, CH_LOCAL, CH_REMOTE} chan_mode_type;
    // transmit frame sequencer
    typedef enum logic [2:0] {TX_IDLE, TX_LEN, TX_DATA, TX_EOF, TX_WAIT, TX_HOLD} tx_state_type;
endpackage
